// ### common/alb_regs.vh
// register offsets, field positions, reset values and timing counts of the analog link bridge
`ifndef ALB_REGS_VH
`define ALB_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ALB_TRIG_SEL_BASE 8'h00
`define ALB_MST_STATUS 8'h20
`define ALB_CTL_STATUS 8'h24
`define ALB_EVT_STATUS 8'h28
`define ALB_EVT_MASK 8'h2C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ALB_ST_POWER 0
`define ALB_ST_CLOCK 1
`define ALB_ST_BUS 2
`define ALB_ST_TRIG 3
`define ALB_ST_INT 4
`define ALB_EV_TIMEOUT 0
`define ALB_EV_REFUSED 1
`define ALB_EV_CLK_LOST 2
`define ALB_EV_PWR_LOST 3
`define ALB_EV_TRIG_FAULT 4
`define ALB_EV_ABNORMAL 5'h1D
`define ALB_EVT_MASK_RST 5'h00
`define ALB_TRIG_SEL_RST 5'h1F

// ----------------------------------------------------------------
// analog register map: results live in one page
// ----------------------------------------------------------------
`define ALB_RESULT_PAGE 4'hF

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ALB_CLK_PERIOD_NS 50
`define ALB_BUS_TMO_NS 2000
// counts below are sized cycles of the 50 ns clock, so no width is lost
`define ALB_BUS_TMO_CYC 8'h28
`define ALB_ACLK_TMO_NS 1000
`define ALB_ACLK_TMO_CYC 8'h14

`endif

// ### src/alb_trig_sel.v
// one start-of-conversion trigger: picks one source by its select value
`timescale 1ns/1ps
module alb_trig_sel #(
  parameter NSRC = 22,
  parameter SW = 5
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  input wire clr,
  // selection
  input wire [SW-1:0] sel,
  input wire [NSRC-1:0] src,
  // trigger
  output reg trig_q
);

  // select values past the last source give a quiet trigger
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_q <= 1'b0;
    end else if (clr) begin
      trig_q <= 1'b0;
    end else if (sel < NSRC) begin
      trig_q <= src[sel];
    end else begin
      trig_q <= 1'b0;
    end
  end

endmodule

// ### src/alb_link_bridge.v
// analog link bridge: arbitration, access rights, trigger routing, interrupt merge, link health
`timescale 1ns/1ps
`include "alb_regs.vh"
module alb_link_bridge #(
  parameter NM = 4,
  parameter AW = 12,
  parameter DW = 32,
  parameter NSRC = 22,
  parameter NTRIG = 8,
  parameter NEOC = 8,
  parameter NDMA = 4,
  parameter SW = 5
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  input wire analog_link_reset,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // bus masters: 0 master cpu, 1 master dma, 2 control cpu, 3 control dma
  input wire [NM-1:0] m_req,
  input wire [NM-1:0] m_we,
  input wire [NM*AW-1:0] m_addr,
  input wire [NM*DW-1:0] m_wdata,
  output reg [NM-1:0] m_ack,
  output reg [NM-1:0] m_err,
  output reg [DW-1:0] m_rdata,
  // analog register side
  output reg ana_req,
  output reg ana_we,
  output reg [AW-1:0] ana_addr,
  output reg [DW-1:0] ana_wdata,
  input wire ana_ack,
  input wire [DW-1:0] ana_rdata,
  // conversion triggers and end-of-conversion
  input wire [NSRC-1:0] soc_src,
  output wire [NTRIG-1:0] soc_trig,
  input wire [NEOC-1:0] first_converter_eoc,
  input wire [NEOC-1:0] second_converter_eoc,
  output reg [NEOC-1:0] master_adc_int,
  output reg [NEOC-1:0] peripheral_interrupt_expander_int,
  output reg [NDMA-1:0] control_dma_trig,
  // analog health
  input wire analog_power_good,
  input wire analog_system_clock_mon,
  // error and interrupt
  output reg analog_link_error,
  output reg irq
);

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_DONE = 2'd2;
  localparam TW = 8;
  localparam [TW-1:0] BUS_TMO = `ALB_BUS_TMO_CYC;
  localparam [TW-1:0] ACLK_TMO = `ALB_ACLK_TMO_CYC;
  localparam [1:0] M_CTL_CPU = 2'd2;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [1:0] state_q;
  reg [1:0] gnt_q;
  reg [1:0] rr_ptr_q;
  reg [TW-1:0] tmo_q;
  reg [SW*NTRIG-1:0] trig_sel_q;
  reg [4:0] evt_q;
  reg [4:0] evt_d;
  reg [4:0] mask_q;
  reg mst_bus_ok_q;
  reg ctl_bus_ok_q;
  reg trig_ok_q;
  reg int_ok_q;
  reg aclk_prev_q;
  reg [TW-1:0] aclk_cnt_q;
  reg aclk_ok_q;
  reg pwr_ok_q;
  reg [4:0] hlth;
  reg [4:0] evt_set;
  reg [1:0] pick;
  reg pick_vld;
  reg [2:0] k;
  reg [1:0] idx;
  wire [AW-1:0] sel_addr;
  wire sel_we;
  wire sel_result;
  wire sel_allowed;
  wire link_up;
  wire w1c_hit;

  assign link_up = aclk_ok_q & pwr_ok_q;
  assign sel_addr = m_addr[pick*AW +: AW];
  assign sel_we = m_we[pick];
  assign sel_result = (sel_addr[AW-1 -: 4] == `ALB_RESULT_PAGE);
  // results read by anyone, writes and other registers only by the control cpu
  assign sel_allowed = (sel_result & ~sel_we) | (pick == M_CTL_CPU);

  // ----------------------------------------------------------------
  // round-robin pick, starting after the last winner
  // ----------------------------------------------------------------
  always @* begin
    pick = 2'd0;
    pick_vld = 1'b0;
    idx = 2'd0;
    for (k = 3'd1; k <= 3'd4; k = k + 3'd1) begin
      idx = rr_ptr_q + k[1:0];
      if (!pick_vld && m_req[idx]) begin
        pick = idx;
        pick_vld = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // bus cycle engine
  // ----------------------------------------------------------------
  // the done state keeps a still-held request from being granted twice
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      gnt_q <= 2'd0;
      rr_ptr_q <= 2'd3;
      tmo_q <= {TW{1'b0}};
      m_ack <= {NM{1'b0}};
      m_err <= {NM{1'b0}};
      m_rdata <= {DW{1'b0}};
      ana_req <= 1'b0;
      ana_we <= 1'b0;
      ana_addr <= {AW{1'b0}};
      ana_wdata <= {DW{1'b0}};
    end else if (analog_link_reset) begin
      state_q <= ST_IDLE;
      gnt_q <= 2'd0;
      rr_ptr_q <= 2'd3;
      tmo_q <= {TW{1'b0}};
      m_ack <= {NM{1'b0}};
      m_err <= {NM{1'b0}};
      m_rdata <= {DW{1'b0}};
      ana_req <= 1'b0;
      ana_we <= 1'b0;
      ana_addr <= {AW{1'b0}};
      ana_wdata <= {DW{1'b0}};
    end else begin
      m_ack <= {NM{1'b0}};
      m_err <= {NM{1'b0}};
      case (state_q)
        ST_IDLE: begin
          if (pick_vld) begin
            gnt_q <= pick;
            rr_ptr_q <= pick;
            if (sel_allowed) begin
              ana_req <= 1'b1;
              ana_we <= sel_we;
              ana_addr <= sel_addr;
              ana_wdata <= m_wdata[pick*DW +: DW];
              tmo_q <= {TW{1'b0}};
              state_q <= ST_WAIT;
            end else begin
              m_ack[pick] <= 1'b1;
              m_err[pick] <= 1'b1;
              m_rdata <= {DW{1'b0}};
              state_q <= ST_DONE;
            end
          end
        end
        ST_WAIT: begin
          if (ana_ack) begin
            ana_req <= 1'b0;
            m_ack[gnt_q] <= 1'b1;
            m_rdata <= ana_we ? {DW{1'b0}} : ana_rdata;
            state_q <= ST_DONE;
          end else if (tmo_q == BUS_TMO - 8'd1) begin
            ana_req <= 1'b0;
            m_ack[gnt_q] <= 1'b1;
            m_err[gnt_q] <= 1'b1;
            m_rdata <= {DW{1'b0}};
            state_q <= ST_DONE;
          end else begin
            tmo_q <= tmo_q + 8'd1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // trigger routing
  // ----------------------------------------------------------------
  genvar t;
  generate
    for (t = 0; t < NTRIG; t = t + 1) begin : g_trig
      alb_trig_sel #(
        .NSRC(NSRC),
        .SW(SW)
      ) u_sel (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clr(analog_link_reset),
        .sel(trig_sel_q[t*SW +: SW]),
        .src(soc_src),
        .trig_q(soc_trig[t])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // end-of-conversion merge
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      master_adc_int <= {NEOC{1'b0}};
      peripheral_interrupt_expander_int <= {NEOC{1'b0}};
      control_dma_trig <= {NDMA{1'b0}};
    end else if (analog_link_reset) begin
      master_adc_int <= {NEOC{1'b0}};
      peripheral_interrupt_expander_int <= {NEOC{1'b0}};
      control_dma_trig <= {NDMA{1'b0}};
    end else begin
      master_adc_int <= first_converter_eoc & second_converter_eoc;
      peripheral_interrupt_expander_int <= first_converter_eoc & second_converter_eoc;
      control_dma_trig <= first_converter_eoc[NDMA-1:0] & second_converter_eoc[NDMA-1:0];
    end
  end

  // ----------------------------------------------------------------
  // link health
  // ----------------------------------------------------------------
  // clock monitor is a sampled level that toggles with the analog clock
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aclk_prev_q <= 1'b0;
      aclk_cnt_q <= {TW{1'b0}};
      aclk_ok_q <= 1'b0;
      pwr_ok_q <= 1'b0;
      mst_bus_ok_q <= 1'b1;
      ctl_bus_ok_q <= 1'b1;
      trig_ok_q <= 1'b1;
      int_ok_q <= 1'b1;
    end else if (analog_link_reset) begin
      aclk_prev_q <= 1'b0;
      aclk_cnt_q <= {TW{1'b0}};
      aclk_ok_q <= 1'b0;
      pwr_ok_q <= 1'b0;
      mst_bus_ok_q <= 1'b1;
      ctl_bus_ok_q <= 1'b1;
      trig_ok_q <= 1'b1;
      int_ok_q <= 1'b1;
    end else begin
      aclk_prev_q <= analog_system_clock_mon;
      pwr_ok_q <= analog_power_good;
      if (analog_system_clock_mon != aclk_prev_q) begin
        aclk_cnt_q <= {TW{1'b0}};
        aclk_ok_q <= 1'b1;
      end else if (aclk_cnt_q == ACLK_TMO - 8'd1) begin
        aclk_ok_q <= 1'b0;
      end else begin
        aclk_cnt_q <= aclk_cnt_q + 8'd1;
      end
      if (state_q == ST_WAIT && (ana_ack || tmo_q == BUS_TMO - 8'd1)) begin
        if (gnt_q[1]) begin
          ctl_bus_ok_q <= ana_ack;
        end else begin
          mst_bus_ok_q <= ana_ack;
        end
      end
      if (|soc_trig) begin
        trig_ok_q <= link_up;
      end
      if (|(first_converter_eoc | second_converter_eoc)) begin
        int_ok_q <= link_up;
      end
    end
  end

  always @* begin
    hlth = 5'h00;
    hlth[`ALB_ST_POWER] = pwr_ok_q;
    hlth[`ALB_ST_CLOCK] = aclk_ok_q;
    hlth[`ALB_ST_TRIG] = trig_ok_q;
    hlth[`ALB_ST_INT] = int_ok_q;
    evt_set = 5'h00;
    evt_set[`ALB_EV_TIMEOUT] = (state_q == ST_WAIT) && !ana_ack && (tmo_q == BUS_TMO - 8'd1);
    evt_set[`ALB_EV_REFUSED] = (state_q == ST_IDLE) && pick_vld && !sel_allowed;
    evt_set[`ALB_EV_CLK_LOST] = aclk_ok_q && (aclk_cnt_q == ACLK_TMO - 8'd1)
                                && (analog_system_clock_mon == aclk_prev_q);
    evt_set[`ALB_EV_PWR_LOST] = pwr_ok_q && !analog_power_good;
    evt_set[`ALB_EV_TRIG_FAULT] = (|soc_trig) && !link_up;
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  assign w1c_hit = reg_wr && (reg_addr == `ALB_EVT_STATUS);

  // a new event in the clearing cycle survives the clear
  always @* begin
    evt_d = evt_q;
    if (w1c_hit) begin
      evt_d = evt_q & ~reg_wdata[4:0];
    end
    evt_d = evt_d | evt_set;
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_sel_q <= {NTRIG{`ALB_TRIG_SEL_RST}};
      mask_q <= `ALB_EVT_MASK_RST;
      evt_q <= 5'h00;
      reg_rdata <= 32'h0000_0000;
      irq <= 1'b0;
      analog_link_error <= 1'b0;
    end else if (analog_link_reset) begin
      trig_sel_q <= {NTRIG{`ALB_TRIG_SEL_RST}};
      mask_q <= `ALB_EVT_MASK_RST;
      evt_q <= 5'h00;
      reg_rdata <= 32'h0000_0000;
      irq <= 1'b0;
      analog_link_error <= 1'b0;
    end else begin
      evt_q <= evt_d;
      irq <= |(evt_d & mask_q);
      analog_link_error <= |(evt_d & `ALB_EV_ABNORMAL);
      if (reg_wr) begin
        if (reg_addr < `ALB_MST_STATUS && reg_addr[1:0] == 2'b00) begin
          trig_sel_q[reg_addr[4:2]*SW +: SW] <= reg_wdata[SW-1:0];
        end else if (reg_addr == `ALB_EVT_MASK) begin
          mask_q <= reg_wdata[4:0];
        end
      end
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        if (reg_addr < `ALB_MST_STATUS && reg_addr[1:0] == 2'b00) begin
          reg_rdata <= {27'h000_0000, trig_sel_q[reg_addr[4:2]*SW +: SW]};
        end else if (reg_addr == `ALB_MST_STATUS) begin
          reg_rdata <= {27'h000_0000, hlth | (5'h01 << `ALB_ST_BUS) & {5{mst_bus_ok_q}}};
        end else if (reg_addr == `ALB_CTL_STATUS) begin
          reg_rdata <= {27'h000_0000, hlth | (5'h01 << `ALB_ST_BUS) & {5{ctl_bus_ok_q}}};
        end else if (reg_addr == `ALB_EVT_STATUS) begin
          reg_rdata <= {27'h000_0000, evt_q};
        end else if (reg_addr == `ALB_EVT_MASK) begin
          reg_rdata <= {27'h000_0000, mask_q};
        end
      end
    end
  end

endmodule

// ### testbench/alb_assertions.sv
// port checker of the analog link bridge
`timescale 1ns/1ps
module alb_assertions (
  // clock and resets
  input wire sys_clk,
  input wire rst_n,
  input wire analog_link_reset,
  // register port and masters
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire [3:0] m_ack,
  input wire [3:0] m_err,
  // analog side
  input wire ana_req,
  input wire ana_ack,
  input wire [11:0] ana_addr,
  // events and health
  input wire [7:0] first_converter_eoc,
  input wire [7:0] second_converter_eoc,
  input wire [7:0] master_adc_int,
  input wire [7:0] peripheral_interrupt_expander_int,
  input wire [3:0] control_dma_trig,
  input wire analog_link_error,
  input wire irq
);
  // ----
  // length of one analog wait
  // ----
  reg [7:0] wait_q;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) wait_q <= 8'h00;
    else wait_q <= ana_req ? wait_q + 8'h01 : 8'h00;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_ack_onehot: assert property ($onehot0(m_ack)) else $error("two masters acknowledged");
  a_err_with_ack: assert property ((m_err & ~m_ack) == 4'h0) else $error("error without ack");
  a_ack_single: assert property (m_ack != 4'h0 |=> m_ack == 4'h0) else $error("ack too long");
  a_ana_done: assert property (ana_req && ana_ack && !analog_link_reset |=> !ana_req && m_ack != 4'h0)
    else $error("analog answer not passed on");
  a_ana_hold: assert property (ana_req && !ana_ack && !analog_link_reset |=> !ana_req || $stable(ana_addr))
    else $error("analog address moved");
  a_int_merge: assert property (!analog_link_reset |=> master_adc_int == $past(first_converter_eoc &
    second_converter_eoc) && peripheral_interrupt_expander_int == master_adc_int) else $error("bad merge");
  a_dma_four: assert property (control_dma_trig == master_adc_int[3:0]) else $error("bad dma trigger");
  a_link_reset: assert property (analog_link_reset |=> m_ack == 4'h0 && !ana_req && !irq && !analog_link_error)
    else $error("bridge reset ignored");
  a_wait_bound: assert property (wait_q <= 8'd40) else $error("analog wait too long");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000) else $error("stray read data");
endmodule
bind alb_link_bridge alb_assertions u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .analog_link_reset(analog_link_reset), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .m_ack(m_ack), .m_err(m_err),
  .ana_req(ana_req), .ana_ack(ana_ack), .ana_addr(ana_addr), .first_converter_eoc(first_converter_eoc),
  .second_converter_eoc(second_converter_eoc), .master_adc_int(master_adc_int),
  .peripheral_interrupt_expander_int(peripheral_interrupt_expander_int), .control_dma_trig(control_dma_trig),
  .analog_link_error(analog_link_error), .irq(irq));

// ### testbench/alb_ana_model.sv
// analog register side answering the bridge after a chosen delay
`timescale 1ns/1ps
module alb_ana_model (
  // clock and behaviour
  input wire sys_clk,
  input wire [3:0] dly,
  input wire mute,
  // bridge side
  input wire ana_req,
  input wire [11:0] ana_addr,
  output logic ana_ack,
  output logic [31:0] ana_rdata
);
  logic [3:0] cnt_q;
  wire hit = ana_req && !ana_ack && cnt_q == dly && !mute;
  // the bridge holds ana_req low in reset, which settles ack and count
  always @(posedge sys_clk) begin
    ana_ack <= hit;
    // data outside the answer differs from any answer, so stale sampling shows
    ana_rdata <= hit ? {8'hA5, 12'h000, ana_addr} : {8'h5A, 12'hFFF, ~ana_addr};
    cnt_q <= (!ana_req || ana_ack || hit) ? 4'h0 : cnt_q + 4'h1;
  end
endmodule

// ### testbench/alb_link_bridge_bench.sv
// self-checking bench of the analog link bridge
`timescale 1ns/1ps
module alb_link_bridge_bench;
  logic sys_clk, rst_n, analog_link_reset, reg_wr, reg_rd, ana_req, ana_we, ana_ack, mute, rd_seen;
  logic analog_power_good, analog_system_clock_mon, analog_link_error, irq, ok;
  logic [7:0] reg_addr, soc_trig, first_converter_eoc, second_converter_eoc;
  logic [7:0] master_adc_int, peripheral_interrupt_expander_int;
  logic [31:0] reg_wdata, reg_rdata, m_rdata, ana_wdata, ana_rdata, wd;
  logic [3:0] m_req, m_we, m_ack, m_err, control_dma_trig, dly;
  logic [47:0] m_addr;
  logic [127:0] m_wdata;
  logic [11:0] ana_addr, a;
  logic [21:0] soc_src;
  logic [4:0] sel [8];
  logic [39:0] me;
  logic [39:0] mq [$];
  logic [31:0] rq [$];
  logic [32:0] wq [$];
  logic [32:0] wx;
  int failures, checks_done, cyc, last, t, i, k;
  alb_link_bridge u_dut (.sys_clk, .rst_n, .analog_link_reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .m_req, .m_we, .m_addr, .m_wdata, .m_ack, .m_err, .m_rdata, .ana_req, .ana_we, .ana_addr,
    .ana_wdata, .ana_ack, .ana_rdata, .soc_src, .soc_trig, .first_converter_eoc, .second_converter_eoc,
    .master_adc_int, .peripheral_interrupt_expander_int, .control_dma_trig, .analog_power_good,
    .analog_system_clock_mon, .analog_link_error, .irq);
  alb_ana_model u_ana (.sys_clk, .dly, .mute, .ana_req, .ana_addr, .ana_ack, .ana_rdata);
  // ----
  // clock, checks, monitor
  // ----
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    analog_system_clock_mon <= rst_n ? ~analog_system_clock_mon : 1'b0;
    rd_seen <= reg_rd;
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  always @(negedge sys_clk) begin
    if (rd_seen) chk("reg_rdata", reg_rdata, rq.size() ? rq.pop_front() : 32'hDEAD_BEEF);
    if (m_ack !== 4'h0) begin
      me = mq.size() ? mq.pop_front() : 40'h00_0000_0000;
      chk("m_ack", m_ack, me[39:36]);
      chk("m_err", m_err, me[35:32]);
      chk("m_rdata", m_rdata, me[31:0]);
    end
    // analog side cycle: direction always, write data only on writes
    if (ana_req === 1'b1 && ana_ack === 1'b1) begin
      wx = wq.size() ? wq.pop_front() : {1'b1, 32'hDEAD_BEEF};
      chk("ana_we", ana_we, wx[32]);
      if (wx[32]) chk("ana_wdata", ana_wdata, wx[31:0]);
    end
  end
  // ----
  // bus tasks
  // ----
  task automatic rw(input logic [7:0] ad, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rr(input logic [7:0] ad, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    rq.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic ex(input int m, input logic e, input logic [31:0] d);
    mq.push_back({4'h1 << m, e ? 4'h1 << m : 4'h0, d});
  endtask
  task automatic mb(input int m, input logic we, input logic [11:0] ad);
    int n;
    @(posedge sys_clk);
    m_we[m] <= we;
    m_addr[m*12 +: 12] <= ad;
    m_wdata[m*32 +: 32] <= wd;
    m_req[m] <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (m_ack[m] !== 1'b1 && n < 80);
    m_req[m] <= 1'b0;
    last = m;
  endtask
  task automatic wt2;
    repeat (2) @(posedge sys_clk);
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    {rst_n, analog_link_reset, reg_wr, reg_rd, mute} = 5'h00;
    {reg_addr, reg_wdata, m_req, m_we, m_addr, m_wdata, soc_src} = 0;
    {first_converter_eoc, second_converter_eoc} = 16'h0000;
    analog_power_good = 1'b1;
    dly = 4'h1;
    {failures, checks_done, last} = 0;
    last = 3;
    void'($urandom(32'hf90e));
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (30) @(posedge sys_clk);
    for (t = 0; t < 8; t++) rr(8'(4 * t), 32'h0000_001F);
    rw(8'h28, 32'h0000_001F);
    rr(8'h20, 32'h0000_001F);
    rr(8'h24, 32'h0000_001F);
    rw(8'h24, 32'h0000_0000);
    rr(8'h24, 32'h0000_001F);
    rr(8'h30, 32'h0000_0000);
    chk("analog_link_error", analog_link_error, 0);
    for (t = 0; t < 8; t++) begin
      sel[t] = (t == 7) ? 5'd22 : 5'($urandom_range(21, 0));
      rw(8'(4 * t), 32'(sel[t]));
    end
    repeat (4) begin
      @(posedge sys_clk);
      soc_src <= 22'($urandom);
      wt2();
      for (t = 0; t < 8; t++) chk("soc_trig", soc_trig[t], sel[t] < 22 ? soc_src[sel[t]] : 1'b0);
    end
    repeat (6) begin
      @(posedge sys_clk);
      first_converter_eoc <= 8'($urandom);
      second_converter_eoc <= 8'($urandom);
      wt2();
      chk("adc_int", master_adc_int, first_converter_eoc & second_converter_eoc);
      chk("pie_int", peripheral_interrupt_expander_int, first_converter_eoc & second_converter_eoc);
      chk("dma_trig", control_dma_trig, first_converter_eoc[3:0] & second_converter_eoc[3:0]);
    end
    for (i = 0; i < 4; i++) for (k = 0; k < 3; k++) begin
      a = {k == 1 ? 4'h3 : 4'hF, 8'($urandom)};
      ok = (i == 2) || (k == 0);
      ex(i, !ok, ok && k != 2 ? {8'hA5, 12'h000, a} : 32'h0000_0000);
      wd = $urandom;
      if (ok) wq.push_back({k == 2, wd});
      dly <= 4'($urandom_range(6, 0));
      mb(i, k == 2, a);
    end
    for (k = 1; k <= 4; k++) ex((last + k) % 4, 0, {8'hA5, 12'h000, 12'hF00 + 12'((last + k) % 4)});
    repeat (4) wq.push_back({1'b0, wd});
    fork
      mb(0, 0, 12'hF00);
      mb(1, 0, 12'hF01);
      mb(2, 0, 12'hF02);
      mb(3, 0, 12'hF03);
    join
    mute <= 1'b1;
    ex(2, 1, 32'h0000_0000);
    mb(2, 0, 12'hF10);
    mute <= 1'b0;
    rr(8'h24, 32'h0000_001B);
    rr(8'h20, 32'h0000_001F);
    rr(8'h28, 32'h0000_0003);
    chk("analog_link_error", analog_link_error, 1);
    chk("irq", irq, 0);
    rw(8'h2C, 32'h0000_0002);
    wt2();
    chk("irq", irq, 1);
    rw(8'h28, 32'h0000_0002);
    wt2();
    chk("irq", irq, 0);
    chk("analog_link_error", analog_link_error, 1);
    rw(8'h28, 32'h0000_0001);
    wt2();
    chk("analog_link_error", analog_link_error, 0);
    rw(8'h00, 32'h0000_0003);
    rw(8'h2C, 32'h0000_001F);
    @(posedge sys_clk);
    analog_link_reset <= 1'b1;
    @(posedge sys_clk);
    analog_link_reset <= 1'b0;
    rr(8'h00, 32'h0000_001F);
    rr(8'h2C, 32'h0000_0000);
    // analog power drops while conversions end: power and interrupt health fall
    @(posedge sys_clk);
    analog_power_good <= 1'b0;
    {first_converter_eoc, second_converter_eoc} <= 16'hFFFF;
    wt2();
    rr(8'h20, 32'h0000_000E);
    rr(8'h24, 32'h0000_000E);
    rr(8'h28, 32'h0000_0008);
    chk("analog_link_error", analog_link_error, 1);
    analog_power_good <= 1'b1;
    wt2();
    chk("queue", mq.size() + rq.size() + wq.size(), 0);
    end_sim();
  end
endmodule
